// File: logic/sram_port_pkg.sv
// Constants and types shared by the burst SRAM port and its write buffer.
// Assumes one clock domain; all widths fixed at the device's organisation.
package sram_port_pkg;

    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 36;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int MEM_WORDS  = 131072;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = ADDR_W + DATA_W + LANES;
    localparam int CTRL_W     = 11;
    localparam int IN_W       = ADDR_W + DATA_W + LANES + CTRL_W;

    // Synchroniser reset: all ones, so active-low controls read inactive, high select and sleep read active
    localparam logic [IN_W-1:0]   SYNC_RST  = '1;
    localparam logic [1:0]        CNT_RST   = 2'h0;
    localparam logic [1:0]        CNT_STEP  = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 17'h0_0000;
    localparam logic [DATA_W-1:0] DQ_RST    = 36'h0_0000_0000;
    localparam logic [LANES-1:0]  LANE_ALL  = 4'hF;
    localparam logic [LANES-1:0]  LANE_NONE = 4'h0;

    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_RUN   = 2'b01,
        BURST_SLEEP = 2'b11
    } burst_state_t;

endpackage : sram_port_pkg

// File: logic/stream_if.sv
// Valid/ready word channel between the port logic and its write buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : stream_if

// File: logic/stream_fifo.sv
// Word FIFO with valid/ready on both sides, parameterised width and depth.
// Assumes a power-of-two depth and a single clock.
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic resetn,
    stream_if.dst     fill,
    stream_if.src     drain
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] PTR_RST  = '0;
    localparam logic [PW-1:0] PTR_STEP = PW'(1);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    wire              full;
    wire              empty;
    wire              push;
    wire              pop;

    // Full when the pointers differ only in the wrap bit
    assign full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign push  = fill.valid && !full;
    assign pop   = drain.ready && !empty;

    assign fill.ready  = !full;
    assign drain.valid = !empty;
    assign drain.data  = store[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr_ff[AW-1:0]] <= fill.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= PTR_RST;
            rd_ptr_ff <= PTR_RST;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + PTR_STEP;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + PTR_STEP;
            end
        end
    end

endmodule : stream_fifo

// File: logic/burst_sram_port.sv
// Pipelined burst SRAM port: four-word bursts, strobes, byte writes, sleep.
// Assumes pins arrive asynchronously and are synchronised here; one clock.
//
// Contract
// - A burst moves four words from one base address, stepping only the two low bits in burst order.
// - A high advance input holds the burst counter so the current word is reused.
// - Burst and address registers are not kept across sleep; a new external cycle is needed.
// - Either address strobe starts a read with an external address.
// - Writes start only with the controller strobe while the processor strobe is high.
// - Global write and byte-write enable with all lanes give the same result.
// - Selection needs chip enable low, high select high and low select low.
// - After the fourth word the counter wraps to the starting low address.
// - Several byte lanes may be written in one cycle.
`timescale 1ns/1ps
module burst_sram_port (
    input  wire logic                               clk,
    input  wire logic                               resetn,
    input  wire logic [sram_port_pkg::ADDR_W-1:0]   addr,
    input  wire logic                               chip_enable_n,
    input  wire logic                               select_hi,
    input  wire logic                               select_lo_n,
    input  wire logic                               proc_addr_strobe_n,
    input  wire logic                               ctrl_addr_strobe_n,
    input  wire logic                               burst_advance_n,
    input  wire logic                               global_write_n,
    input  wire logic                               byte_write_enable_n,
    input  wire logic [sram_port_pkg::LANES-1:0]    byte_lane_select_n,
    input  wire logic                               burst_order_sel,
    input  wire logic                               output_enable_n,
    input  wire logic                               sleep_req,
    input  wire logic [sram_port_pkg::DATA_W-1:0]   dq_in,
    output logic      [sram_port_pkg::DATA_W-1:0]   dq_out,
    output logic                                    dq_oe_n,
    output logic                                    fill_ready
);
    import sram_port_pkg::*;

    // Write lane mask from global write, byte-write enable and lane selects
    function automatic logic [LANES-1:0] write_mask(
        input logic             gw_n,
        input logic             bwe_n,
        input logic [LANES-1:0] bw_n
    );
        if (!gw_n) begin
            return LANE_ALL;
        end else if (!bwe_n) begin
            return ~bw_n;
        end
        return LANE_NONE;
    endfunction : write_mask

    // Low address bits for burst step: interleaved when order select is high
    function automatic logic [1:0] burst_low(
        input logic [1:0] base,
        input logic [1:0] step,
        input logic       interleave
    );
        if (interleave) begin
            return base ^ step;
        end
        return 2'(base + step);
    endfunction : burst_low

    logic [IN_W-1:0]   sync1_ff;
    logic [IN_W-1:0]   sync2_ff;
    burst_state_t      state_ff;
    burst_state_t      nxt_state;
    logic [ADDR_W-1:0] base_ff;
    logic [1:0]        cnt_ff;
    logic [DATA_W-1:0] dq_out_ff;
    logic              dq_oe_n_ff;
    logic              fill_ready_ff;
    logic [DATA_W-1:0] mem [0:MEM_WORDS-1];

    wire [IN_W-1:0]    pins_raw;
    wire [ADDR_W-1:0]  s_addr;
    wire [DATA_W-1:0]  s_dq;
    wire [LANES-1:0]   s_bw_n;
    wire               s_ce_n;
    wire               s_hi;
    wire               s_lo_n;
    wire               s_psn;
    wire               s_csn;
    wire               s_adv_n;
    wire               s_gw_n;
    wire               s_bwe_n;
    wire               s_lbo;
    wire               s_oe_n;
    wire               s_zz;

    wire               selected;
    wire               start_p;
    wire               start_c;
    wire               start;
    wire               deselect;
    wire               cont;
    wire               access;
    wire [LANES-1:0]   wmask;
    wire               is_write;
    wire               rd_access;
    wire [1:0]         nxt_cnt;
    wire [ADDR_W-1:0]  base_sel;
    wire [ADDR_W-1:0]  cur_addr;
    wire [DATA_W-1:0]  rd_word;

    wire [ADDR_W-1:0]  dr_addr;
    wire [DATA_W-1:0]  dr_data;
    wire [LANES-1:0]   dr_mask;
    wire               dr_write;
    wire [DATA_W-1:0]  old_word;
    wire [DATA_W-1:0]  merged_word;

    stream_if #(.W(FIFO_W)) wq_in ();
    stream_if #(.W(FIFO_W)) wq_out ();

    // Two-flop synchronisers on every pin
    assign pins_raw = {addr, dq_in, byte_lane_select_n, chip_enable_n, select_hi,
                       select_lo_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
                       burst_advance_n, global_write_n, byte_write_enable_n,
                       burst_order_sel, output_enable_n, sleep_req};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    assign {s_addr, s_dq, s_bw_n, s_ce_n, s_hi, s_lo_n, s_psn, s_csn, s_adv_n,
            s_gw_n, s_bwe_n, s_lbo, s_oe_n, s_zz} = sync2_ff;

    // Cycle decode
    assign selected  = !s_ce_n && s_hi && !s_lo_n;
    assign start_p   = !s_psn && selected;
    assign start_c   = s_psn && !s_csn && selected;
    assign start     = (start_p || start_c) && !s_zz;
    assign deselect  = !selected && (!s_csn || (!s_psn && !s_ce_n));
    assign cont      = (state_ff == BURST_RUN) && s_csn && (s_psn || s_ce_n)
                       && !s_zz;
    assign access    = start || cont;
    assign wmask     = write_mask(s_gw_n, s_bwe_n, s_bw_n);
    assign is_write  = (start_c || cont) && (wmask != LANE_NONE);
    assign rd_access = access && !is_write;

    // Burst address: hold on suspend, step on advance, wrap in two bits
    assign nxt_cnt  = start ? CNT_RST
                    : (s_adv_n ? cnt_ff : 2'(cnt_ff + CNT_STEP));
    assign base_sel = start ? s_addr : base_ff;
    assign cur_addr = {base_sel[ADDR_W-1:2],
                       burst_low(base_sel[1:0], nxt_cnt, s_lbo)};
    assign rd_word  = mem[cur_addr];

    // Burst state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BURST_IDLE: begin
                if (start) begin
                    nxt_state = BURST_RUN;
                end
            end
            BURST_RUN: begin
                if (start) begin
                    nxt_state = BURST_RUN;
                end else if (deselect) begin
                    nxt_state = BURST_IDLE;
                end
            end
            BURST_SLEEP: begin
                nxt_state = BURST_IDLE;
            end
            default: begin
                nxt_state = BURST_IDLE;
            end
        endcase
        if (s_zz) begin
            nxt_state = BURST_SLEEP;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= BURST_SLEEP;
            base_ff  <= ADDR_RST;
            cnt_ff   <= CNT_RST;
        end else begin
            state_ff <= nxt_state;
            if (s_zz) begin
                base_ff <= ADDR_RST;
                cnt_ff  <= CNT_RST;
            end else if (access) begin
                base_ff <= base_sel;
                cnt_ff  <= nxt_cnt;
            end
        end
    end

    // Writes queue in the buffer; it drains only in cycles with no read
    assign wq_in.valid  = access && is_write;
    assign wq_in.data   = {cur_addr, s_dq, wmask};
    assign wq_out.ready = !rd_access;

    stream_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_fifo (
        .clk    (clk),
        .resetn (resetn),
        .fill   (wq_in),
        .drain  (wq_out)
    );

    assign {dr_addr, dr_data, dr_mask} = wq_out.data;
    assign dr_write = wq_out.valid && wq_out.ready;
    assign old_word = mem[dr_addr];

    // Merge every selected lane into the stored word
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign merged_word[i*LANE_W +: LANE_W] = dr_mask[i]
            ? dr_data[i*LANE_W +: LANE_W]
            : old_word[i*LANE_W +: LANE_W];
    end

    always_ff @(posedge clk) begin
        if (dr_write) begin
            mem[dr_addr] <= merged_word;
        end
    end

    // Read data registered for the next edge; drive gated by output enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_out_ff     <= DQ_RST;
            dq_oe_n_ff    <= 1'b1;
            fill_ready_ff <= 1'b0;
        end else begin
            if (rd_access) begin
                dq_out_ff <= rd_word;
            end
            dq_oe_n_ff    <= !(rd_access && !s_oe_n);
            fill_ready_ff <= wq_in.ready;
        end
    end

    assign dq_out     = dq_out_ff;
    assign dq_oe_n    = dq_oe_n_ff;
    assign fill_ready = fill_ready_ff;

endmodule : burst_sram_port

// File: sim/bus_ctrl_model.sv
// Controller model that drives the port's synchronous pins, one cycle per call.
// Assumes the bench calls cyc from a single process.
`timescale 1ns/1ps
module bus_ctrl_model (
    input  wire logic                             clk,
    output logic      [sram_port_pkg::ADDR_W-1:0] addr,
    output logic                                  chip_enable_n,
    output logic                                  select_hi,
    output logic                                  select_lo_n,
    output logic                                  proc_addr_strobe_n,
    output logic                                  ctrl_addr_strobe_n,
    output logic                                  burst_advance_n,
    output logic                                  global_write_n,
    output logic                                  byte_write_enable_n,
    output logic      [sram_port_pkg::LANES-1:0]  byte_lane_select_n,
    output logic      [sram_port_pkg::DATA_W-1:0] dq_in
);
    import sram_port_pkg::*;

    initial begin
        {chip_enable_n, select_hi, select_lo_n, proc_addr_strobe_n} = 4'hB;
        {ctrl_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n} = 4'hF;
        byte_lane_select_n = LANE_ALL;
        addr = ADDR_RST;
        dq_in = DQ_RST;
    end

    // Control byte: ce_n, hi, lo_n, proc strobe, ctrl strobe, advance, global write, byte enable
    task automatic cyc(input logic [7:0] c, input logic [LANES-1:0] bw,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        {chip_enable_n, select_hi, select_lo_n, proc_addr_strobe_n} <= c[7:4];
        {ctrl_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n} <= c[3:0];
        byte_lane_select_n <= bw;
        addr <= a;
        dq_in <= (c[1] && c[0]) ? ~dq_in : d;  // Unused data lines keep toggling
    endtask : cyc
endmodule : bus_ctrl_model

// File: sim/burst_sram_port_properties.sv
// Pin-level checker for the burst SRAM port.
// Assumes one clock; bound onto burst_sram_port below.
`timescale 1ns/1ps
module burst_sram_port_properties (
    input wire logic                             clk,
    input wire logic                             resetn,
    input wire logic                             chip_enable_n,
    input wire logic                             select_hi,
    input wire logic                             select_lo_n,
    input wire logic                             proc_addr_strobe_n,
    input wire logic                             ctrl_addr_strobe_n,
    input wire logic                             burst_advance_n,
    input wire logic                             global_write_n,
    input wire logic                             byte_write_enable_n,
    input wire logic                             output_enable_n,
    input wire logic                             sleep_req,
    input wire logic [sram_port_pkg::DATA_W-1:0] dq_out,
    input wire logic                             dq_oe_n
);
    import sram_port_pkg::*;
    logic [2:0] calm_ff;
    logic [2:0] nxt_calm;
    logic       sel;
    logic       ok;
    logic       acc;
    assign sel = !chip_enable_n && select_hi && !select_lo_n;
    assign ok = (calm_ff == 3'h7) && !sleep_req;
    assign acc = !proc_addr_strobe_n || !ctrl_addr_strobe_n || !burst_advance_n;
    assign nxt_calm = sleep_req ? 3'h0 : ((calm_ff == 3'h7) ? calm_ff : calm_ff + 3'h1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) calm_ff <= 3'h0;
        else calm_ff <= nxt_calm;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_rd_proc;
        ok && sel && !proc_addr_strobe_n && !output_enable_n;
    endsequence
    sequence s_rd_ctrl;
        ok && sel && proc_addr_strobe_n && !ctrl_addr_strobe_n && global_write_n
            && byte_write_enable_n && !output_enable_n;
    endsequence
    sequence s_wake;
        $fell(sleep_req) ##0 (proc_addr_strobe_n && ctrl_addr_strobe_n) [*6];
    endsequence

    chk_read_proc: assert property (s_rd_proc |-> ##3 !dq_oe_n)
        else $error("processor strobe read gave no data");
    chk_read_ctrl: assert property (s_rd_ctrl |-> ##3 !dq_oe_n)
        else $error("controller strobe read gave no data");
    chk_oe_gate: assert property (output_enable_n [*4] |=> dq_oe_n)
        else $error("data driven while output enable off");
    chk_desel_quiet: assert property (ok && !ctrl_addr_strobe_n
        && (chip_enable_n || !select_hi || select_lo_n) |-> ##3 dq_oe_n)
        else $error("deselected cycle drove data");
    chk_write_quiet: assert property (ok && sel && proc_addr_strobe_n
        && !ctrl_addr_strobe_n && !global_write_n |-> ##3 dq_oe_n)
        else $error("write cycle drove data");
    chk_sleep_quiet: assert property (sleep_req [*4] |=> dq_oe_n)
        else $error("data driven during sleep");
    chk_out_hold: assert property (!$stable(dq_out) |-> $past(acc, 3))
        else $error("read data changed without an access");
    chk_wake_closed: assert property (s_wake |-> dq_oe_n)
        else $error("burst survived sleep");
endmodule : burst_sram_port_properties

bind burst_sram_port burst_sram_port_properties u_chk (.clk, .resetn, .chip_enable_n,
    .select_hi, .select_lo_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
    .global_write_n, .byte_write_enable_n, .output_enable_n, .sleep_req, .dq_out, .dq_oe_n);

// File: sim/burst_sram_port_tb.sv
// Self-checking bench: burst writes and reads, strobes, selects, output enable, sleep.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module burst_sram_port_tb;
    import sram_port_pkg::*;
    logic                clk, resetn, burst_order_sel, output_enable_n, sleep_req;
    logic                chip_enable_n, select_hi, select_lo_n, proc_addr_strobe_n;
    logic                ctrl_addr_strobe_n, burst_advance_n, global_write_n;
    logic                byte_write_enable_n, dq_oe_n, fill_ready;
    logic [ADDR_W-1:0]   addr, b0, b1;
    logic [LANES-1:0]    byte_lane_select_n;
    logic [DATA_W-1:0]   dq_in, dq_out, e;
    logic [DATA_W-1:0]   mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0]   exp_q [$];
    logic [7:0]          bad [3] = '{8'hD5, 8'h15, 8'h75};
    int                  n_errors = 0;
    int                  checks_done = 0;
    int                  seed = 1;

    burst_sram_port u_dut (.clk, .resetn, .addr, .chip_enable_n, .select_hi, .select_lo_n,
        .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .global_write_n,
        .byte_write_enable_n, .byte_lane_select_n, .burst_order_sel, .output_enable_n,
        .sleep_req, .dq_in, .dq_out, .dq_oe_n, .fill_ready);
    bus_ctrl_model u_ctrl (.clk, .addr, .chip_enable_n, .select_hi, .select_lo_n,
        .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .global_write_n,
        .byte_write_enable_n, .byte_lane_select_n, .dq_in);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Deselect cycles: close any open burst so no suspend read follows, let writes drain
    task automatic idle(input int n);
        repeat (n) u_ctrl.cyc(8'hB7, LANE_ALL, ADDR_RST, DQ_RST);
    endtask : idle

    // Start, advance, suspend, advance, advance, wrap
    task automatic burst(input logic [7:0] s, input logic wr, input logic [LANES-1:0] bw,
                         input logic [ADDR_W-1:0] base);
        int                ns [6] = '{0, 1, 1, 2, 3, 0};
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        for (int k = 0; k < 6; k++) begin
            a = {base[ADDR_W-1:2], burst_order_sel ? base[1:0] ^ 2'(ns[k])
                                                   : base[1:0] + 2'(ns[k])};
            if (k != 2) d = DATA_W'({$random(seed), $random(seed)});
            if (wr) begin
                for (int i = 0; i < LANES; i++) begin
                    if (!bw[i] || !s[1]) mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
                end
            end else if (!output_enable_n) begin
                exp_q.push_back(mem[a]);
            end
            u_ctrl.cyc((k == 0) ? s : {s[7:5], 2'b11, (k == 2), s[1:0]}, bw, base, d);
        end
    endtask : burst

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    always @(negedge clk) begin
        if (resetn === 1'b1 && dq_oe_n === 1'b0) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
            `CHK("dq_out", e, dq_out)
        end
    end

    initial begin
        resetn = 1'b0;
        burst_order_sel = 1'b0;
        output_enable_n = 1'b0;
        sleep_req = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        idle(6);
        `CHK("fill_ready", 1'b1, fill_ready)
        for (int p = 0; p < 2; p++) begin
            burst_order_sel <= p[0];  // Takes effect with the prior burst's wrap cycle, where step 0 reads the same address in either order
            idle(4);
            b0 = ADDR_W'($random(seed));
            b1 = ADDR_W'($random(seed));
            burst(8'h55, 1'b1, LANE_ALL, b0);
            burst(8'h56, 1'b1, LANE_NONE, b1);
            burst(8'h56, 1'b1, 4'h5, b0);
            idle(8);
            burst(8'h57, 1'b0, LANE_ALL, b0);
            burst(8'h4F, 1'b0, LANE_ALL, b1);
        end
        exp_q.push_back(mem[b0]);
        u_ctrl.cyc(8'h4D, LANE_NONE, b0, '1);  // Write controls ignored
        foreach (bad[i]) u_ctrl.cyc(bad[i], LANE_ALL, b0, '1);
        u_ctrl.cyc(8'h59, LANE_ALL, b0, '1);  // No open burst
        idle(8);
        exp_q.push_back(mem[b0]);
        u_ctrl.cyc(8'h57, LANE_ALL, b0, DQ_RST);
        idle(1);
        output_enable_n <= 1'b1;
        u_ctrl.cyc(8'h57, LANE_ALL, b1, DQ_RST);  // Read with drive off
        u_ctrl.cyc(8'hBB, LANE_ALL, b1, DQ_RST);
        sleep_req <= 1'b1;
        repeat (6) u_ctrl.cyc(8'hBB, LANE_ALL, b1, DQ_RST);  // Strobes high across wake
        sleep_req <= 1'b0;
        output_enable_n <= 1'b0;
        repeat (8) u_ctrl.cyc(8'hBB, LANE_ALL, b1, DQ_RST);
        exp_q.push_back(mem[b1]);
        u_ctrl.cyc(8'h4F, LANE_ALL, b1, DQ_RST);
        idle(2);
        for (int t = 0; t < 20 && exp_q.size() != 0; t++) @(posedge clk);
        `CHK("pending", 0, exp_q.size())
        conclude();
    end
endmodule : burst_sram_port_tb
